// *** pcl_clock_lines.sv ***
// pcl_clock_lines: polarity buffers and edge detect for the eight clock lines
// assumes line inputs are already synchronised to ref_clk
`timescale 1ns/1ps
module pcl_clock_lines #(
	parameter int LINES = pcl_pkg::LINE_COUNT
) (
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic [LINES-1:0] lineIn,
	input  wire logic [LINES-1:0] lineInvert,
	output logic      [LINES-1:0] lineLevel,
	output logic      [LINES-1:0] lineRise
);
	logic [LINES-1:0] prev_reg;
	logic [LINES-1:0] prev_next;

	// polarity is per line so every cell on the line sees one sense
	always_comb
	begin
		lineLevel = lineIn ^ lineInvert;
		lineRise  = lineLevel & ~prev_reg;
		prev_next = lineLevel;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			prev_reg <= '0;
		else
			prev_reg <= prev_next;
	end
endmodule : pcl_clock_lines

// *** pcl_pad_cell.sv ***
// pcl_pad_cell: a group of configurable pad cells along the die edges
// assumes configuration is written by a loader while cfgLoading is high;
// pins arrive asynchronously and are synchronised here
`timescale 1ns/1ps
module pcl_pad_cell #(
	parameter int CELLS = 8,
	parameter int LINES = pcl_pkg::LINE_COUNT
) (
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 chipResetN,
	input  wire logic                 cfgLoading,
	input  wire logic                 cfgWrite,
	input  wire logic [7:0]           cfgCell,
	input  wire pcl_pkg::pcl_cfg_s    cfgData,
	input  wire logic                 cfgTtl,
	input  wire logic [LINES-1:0]     cfgLineInvert,
	input  wire logic [7:0]           readCell,
	input  wire logic [LINES-1:0]     clockLine,
	input  wire logic [CELLS-1:0]     padIn,
	input  wire logic [CELLS-1:0]     outData,
	input  wire logic [CELLS-1:0]     triCtl,
	output logic      [CELLS-1:0]     padOut,
	output logic      [CELLS-1:0]     padOeN,
	output logic      [CELLS-1:0]     padPullUp,
	output logic      [CELLS-1:0]     padFast,
	output logic                      padTtl,
	output logic      [CELLS-1:0]     directIn,
	output logic      [CELLS-1:0]     storedIn,
	output pcl_pkg::pcl_cfg_s         readData
);
	// configuration memory, only touched during loading
	pcl_pkg::pcl_cfg_s cfg_reg [CELLS];
	logic [LINES-1:0] inv_reg;
	logic ttl_reg;
	pcl_pkg::pcl_cfg_s rd_reg;
	pcl_pkg::pcl_cfg_s rd_next;

	// two-stage synchronisers for pins, lines and reset
	logic [CELLS-1:0] pinS1_reg;
	logic [CELLS-1:0] pinS2_reg;
	logic [LINES-1:0] clkS1_reg;
	logic [LINES-1:0] clkS2_reg;
	logic             rstS1_reg;
	logic             rstS2_reg;
	logic             clearAll;

	logic [LINES-1:0] lineLevel;
	logic [LINES-1:0] lineRise;
	logic [CELLS-1:0] outStore;
	logic [CELLS-1:0] outNext;
	logic [CELLS-1:0] oeNNext;
	logic [CELLS-1:0] pullNext;
	logic [CELLS-1:0] fastNext;
	logic [CELLS-1:0] directNext;
	logic [CELLS-1:0] storedNow;
	logic [CELLS-1:0] padOut_reg;
	logic [CELLS-1:0] padOeN_reg;
	logic [CELLS-1:0] padPullUp_reg;
	logic [CELLS-1:0] padFast_reg;
	logic [CELLS-1:0] directIn_reg;
	logic [CELLS-1:0] storedIn_reg;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			pinS1_reg <= '0;
			pinS2_reg <= '0;
			clkS1_reg <= '0;
			clkS2_reg <= '0;
			rstS1_reg <= 1'h0;
			rstS2_reg <= 1'h0;
		end
		else
		begin
			pinS1_reg <= padIn;
			pinS2_reg <= pinS1_reg;
			clkS1_reg <= clockLine;
			clkS2_reg <= clkS1_reg;
			rstS1_reg <= chipResetN;
			rstS2_reg <= rstS1_reg;
		end
	end

	// storage cleared by loading or by low chip reset
	assign clearAll = cfgLoading | ~rstS2_reg;

	// index width for the cell selects, at least one bit
	localparam int LINE_IDX_SAFE = (CELLS > 1) ? $clog2(CELLS) : 1;

	// config writes only while loading; reads return a frozen copy
	always_comb
	begin
		rd_next = rd_reg;
		if (!cfgLoading && readCell < 8'(CELLS))
			rd_next = cfg_reg[readCell[LINE_IDX_SAFE-1:0]];
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			for (int c = 0; c < CELLS; c++)
				cfg_reg[c] <= pcl_pkg::CFG_DEFAULT;
			inv_reg <= '0;
			ttl_reg <= 1'h1;
			rd_reg  <= pcl_pkg::CFG_DEFAULT;
		end
		else
		begin
			if (cfgLoading)
			begin
				inv_reg <= cfgLineInvert;
				ttl_reg <= cfgTtl;
				if (cfgWrite && cfgCell < 8'(CELLS))
					cfg_reg[cfgCell[LINE_IDX_SAFE-1:0]] <= cfgData;
			end
			rd_reg <= rd_next;
		end
	end

	pcl_clock_lines #(.LINES(LINES)) uLines (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.lineIn     (clkS2_reg),
		.lineInvert (inv_reg),
		.lineLevel  (lineLevel),
		.lineRise   (lineRise)
	);

	// one cell per loop step; cells split evenly over the four edges
	for (genvar c = 0; c < CELLS; c++)
	begin : gCell
		localparam int EDGE = (c * pcl_pkg::EDGE_COUNT) / CELLS;
		localparam int BASE = EDGE * pcl_pkg::LINES_EDGE;
		logic inLine;
		logic inRise;
		logic okLine;
		logic okRise;
		logic dataOut;
		logic ctlRaw;
		logic ctlEff;

		assign inLine = lineLevel[BASE + int'(cfg_reg[c].inLineSel)];
		assign inRise = lineRise[BASE + int'(cfg_reg[c].inLineSel)];
		assign okLine = lineLevel[BASE + int'(cfg_reg[c].outLineSel)];
		assign okRise = lineRise[BASE + int'(cfg_reg[c].outLineSel)];

		pcl_storage uIn (
			.ref_clk   (ref_clk),
			.sys_rst   (sys_rst),
			.clear     (clearAll),
			.asLatch   (cfg_reg[c].inLatch),
			.lineLevel (inLine),
			.lineRise  (inRise),
			.dataIn    (pinS2_reg[c]),
			.dataOut   (storedNow[c])
		);

		// output register is always edge triggered on the rising line
		pcl_storage uOut (
			.ref_clk   (ref_clk),
			.sys_rst   (sys_rst),
			.clear     (clearAll),
			.asLatch   (1'h0),
			.lineLevel (okLine),
			.lineRise  (okRise),
			.dataIn    (outData[c]),
			.dataOut   (outStore[c])
		);

		always_comb
		begin
			dataOut = cfg_reg[c].outRegistered ? outStore[c] : outData[c];
			ctlRaw  = triCtl[c] ^ cfg_reg[c].ctlInvert;
			unique case (cfg_reg[c].driveMode)
				pcl_pkg::DRV_ON:  ctlEff = 1'h0;
				pcl_pkg::DRV_OFF: ctlEff = 1'h1;
				pcl_pkg::DRV_NET: ctlEff = ctlRaw;
				default:          ctlEff = 1'h1;
			endcase
			outNext[c]    = dataOut ^ cfg_reg[c].outInvert;
			oeNNext[c]    = ctlEff;
			// pull-up only when undriven, so it never fights the driver
			pullNext[c]   = cfg_reg[c].pullUpEn & ctlEff;
			fastNext[c]   = cfg_reg[c].fastSlew;
			directNext[c] = pinS2_reg[c];
		end
	end

	// all outputs leave from flip-flops; costs one cycle of latency
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			padOut_reg    <= '0;
			padOeN_reg    <= '1;
			padPullUp_reg <= '0;
			padFast_reg   <= '0;
			directIn_reg  <= '0;
			storedIn_reg  <= '0;
		end
		else
		begin
			padOut_reg    <= outNext;
			padOeN_reg    <= cfgLoading ? '1 : oeNNext;
			padPullUp_reg <= pullNext;
			padFast_reg   <= fastNext;
			directIn_reg  <= directNext;
			storedIn_reg  <= storedNow;
		end
	end

	assign padOut    = padOut_reg;
	assign padOeN    = padOeN_reg;
	assign padPullUp = padPullUp_reg;
	assign padFast   = padFast_reg;
	assign padTtl    = ttl_reg;
	assign directIn  = directIn_reg;
	assign storedIn  = storedIn_reg;
	assign readData  = rd_reg;
endmodule : pcl_pad_cell

// *** pcl_pad_cell_asserts.sv ***
// pcl_pad_cell_asserts: port checks bound onto the pad cell group
// assumes one clock; async inputs pass two sync stages inside
`timescale 1ns/1ps
module pcl_pad_cell_asserts #(
	parameter int CELLS = 8,
	parameter int LINES = pcl_pkg::LINE_COUNT
) (
	input wire logic              ref_clk,
	input wire logic              sys_rst,
	input wire logic              chipResetN,
	input wire logic              cfgLoading,
	input wire logic              cfgTtl,
	input wire logic [CELLS-1:0]  padIn,
	input wire logic [CELLS-1:0]  padOeN,
	input wire logic [CELLS-1:0]  padPullUp,
	input wire logic [CELLS-1:0]  padFast,
	input wire logic              padTtl,
	input wire logic [CELLS-1:0]  directIn,
	input wire logic [CELLS-1:0]  storedIn,
	input wire pcl_pkg::pcl_cfg_s readData
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	// chip-reset clear lags by the sync stages plus the storage and output registers; load clear by the two registers only
	sequence s_loading;
		cfgLoading[*2];
	endsequence
	sequence s_chipLow;
		!chipResetN[*4];
	endsequence
	property p_direct;
		!sys_rst[*4] |-> directIn == $past(padIn, 3);
	endproperty
	a_direct: assert property (p_direct) else $error("direct path");
	property p_loadClr;
		s_loading |=> storedIn == '0;
	endproperty
	a_loadClr: assert property (p_loadClr) else $error("load clr");
	property p_chipClr;
		s_chipLow |=> storedIn == '0;
	endproperty
	a_chipClr: assert property (p_chipClr) else $error("chip clr");
	property p_loadOff;
		cfgLoading |=> padOeN == '1;
	endproperty
	a_loadOff: assert property (p_loadOff) else $error("oe on");
	property p_pullIn;
		(padPullUp & ~padOeN) == '0;
	endproperty
	a_pullIn: assert property (p_pullIn) else $error("pull-up");
	property p_ttl;
		(cfgLoading && $stable(cfgTtl))[*2] |=> padTtl == $past(cfgTtl);
	endproperty
	a_ttl: assert property (p_ttl) else $error("threshold");
	// options settle two edges after loading ends, then hold
	property p_static;
		!cfgLoading[*3] |-> $stable(padTtl) && $stable(padFast);
	endproperty
	a_static: assert property (p_static) else $error("opt moved");
	property p_readHold;
		cfgLoading |=> $stable(readData);
	endproperty
	a_readHold: assert property (p_readHold) else $error("readback");
endmodule : pcl_pad_cell_asserts
bind pcl_pad_cell pcl_pad_cell_asserts #(.CELLS(CELLS), .LINES(LINES))
	u_asserts (
	.ref_clk    (ref_clk),
	.sys_rst    (sys_rst),
	.chipResetN (chipResetN),
	.cfgLoading (cfgLoading),
	.cfgTtl     (cfgTtl),
	.padIn      (padIn),
	.padOeN     (padOeN),
	.padPullUp  (padPullUp),
	.padFast    (padFast),
	.padTtl     (padTtl),
	.directIn   (directIn),
	.storedIn   (storedIn),
	.readData   (readData)
	);

// *** pcl_pad_cell_tb.sv ***
// pcl_pad_cell_tb: self-checking bench for the pad cell group
// assumes package, design, pin model and checker compile first
`timescale 1ns/1ps
module pcl_pad_cell_tb;
	logic              ref_clk, sys_rst, chipResetN, cfgLoading, cfgWrite;
	logic              cfgTtl, padTtl;
	logic [7:0]        cfgCell, readCell, cfgLineInvert, clockLine, padIn;
	logic [7:0]        outData, triCtl, extData, extEn, padOut, padOeN;
	logic [7:0]        padPullUp, padFast, directIn, storedIn;
	pcl_pkg::pcl_cfg_s cfgData, readData;
	pcl_pkg::pcl_cfg_s cf [8];
	int                num_errors, tests_run, cyc;
	pcl_pad_cell #(.CELLS(8)) DUT (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.chipResetN    (chipResetN),
		.cfgLoading    (cfgLoading),
		.cfgWrite      (cfgWrite),
		.cfgCell       (cfgCell),
		.cfgData       (cfgData),
		.cfgTtl        (cfgTtl),
		.cfgLineInvert (cfgLineInvert),
		.readCell      (readCell),
		.clockLine     (clockLine),
		.padIn         (padIn),
		.outData       (outData),
		.triCtl        (triCtl),
		.padOut        (padOut),
		.padOeN        (padOeN),
		.padPullUp     (padPullUp),
		.padFast       (padFast),
		.padTtl        (padTtl),
		.directIn      (directIn),
		.storedIn      (storedIn),
		.readData      (readData)
	);
	pcl_pin_model #(.CELLS(8)) pins (.ref_clk({8{ref_clk}}),
		.padOut(padOut), .padOeN(padOeN), .padPullUp(padPullUp),
		.extData(extData), .extEn(extEn), .pin(padIn));
	initial
	begin
		ref_clk = 1'h0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// hang guard, far past the roughly 130 cycles needed
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic chk(input logic [9:0] got, input logic [9:0] want);
		tests_run++;
		if (got !== want)
		begin
			num_errors++;
			$display("wrong value at %0t: %h not %h", $time, got, want);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("mismatches %0d of %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	// back-to-back writes; loading also clears all storage
	task automatic load(input logic [7:0] inv, input logic ttl);
		cfgLoading = 1'h1;
		cfgLineInvert = inv;
		cfgTtl = ttl;
		for (int i = 0; i < 8; i++)
		begin
			cfgCell = 8'(i);
			cfgData = cf[i];
			cfgWrite = 1'h1;
			tick(1);
		end
		cfgWrite = 1'h0;
		cfgLoading = 1'h0;
		tick(3);
	endtask : load
	task automatic t_outputs;
		outData = 8'h23;
		triCtl = 8'hD0;
		tick(2);
		chk({2'h0, padOeN}, 10'h0C4);
		chk({2'h0, padOut & ~padOeN}, 10'h001);
		chk({2'h0, padPullUp}, 10'h0C4);
		chk({2'h0, padFast}, 10'h002);
		chk({9'h0, padTtl}, 10'h000);
		// cell 5 registers on line 5 only; line 4 must not clock it
		clockLine = 8'h10;
		tick(2);
		clockLine = 8'h00;
		tick(6);
		chk({2'h0, padOut & ~padOeN}, 10'h001);
		clockLine = 8'h20;
		tick(2);
		clockLine = 8'h00;
		tick(6);
		chk({2'h0, padOut & ~padOeN}, 10'h021);
		// open drain: one net feeds both data and control
		outData = 8'h08;
		triCtl = 8'hD8;
		tick(6);
		chk({2'h0, directIn & 8'h0C}, 10'h00C);
		outData = 8'h00;
		triCtl = 8'hD0;
		tick(6);
		chk({2'h0, directIn & 8'h0C}, 10'h004);
	endtask : t_outputs
	task automatic t_chipReset;
		chipResetN = 1'h0;
		tick(5);
		chk({2'h0, storedIn | (padOut & 8'h20)}, 10'h000);
		chipResetN = 1'h1;
		tick(2);
	endtask : t_chipReset
	// cell 6 flip-flop and cell 7 latch share line 6
	task automatic t_inputs;
		// cell 2 stores on the edge's second line, not on line 2
		clockLine = 8'h04;
		tick(6);
		chk({2'h0, storedIn & 8'h04}, 10'h000);
		clockLine = 8'h0C;
		tick(6);
		chk({2'h0, storedIn & 8'h04}, 10'h004);
		clockLine = 8'h00;
		extEn = 8'hC0;
		extData = 8'hC0;
		tick(6);
		chk({2'h0, storedIn & 8'hC0}, 10'h080);
		clockLine = 8'h40;
		tick(6);
		extData = 8'h00;
		tick(6);
		chk({2'h0, storedIn & 8'hC0}, 10'h0C0);
		clockLine = 8'h00;
		tick(6);
		chk({2'h0, storedIn & 8'hC0}, 10'h040);
		load(8'h40, 1'h1);
		extData = 8'hC0;
		clockLine = 8'h40;
		tick(6);
		chk({2'h0, storedIn & 8'hC0}, 10'h080);
		clockLine = 8'h00;
		tick(6);
		chk({2'h0, storedIn & 8'hC0}, 10'h0C0);
		chk({9'h0, padTtl}, 10'h001);
	endtask : t_inputs
	// a stray write to the read cell outside loading must change nothing
	task automatic t_readback;
		readCell = 8'h01;
		cfgCell = 8'h01;
		cfgData = cf[2];
		cfgWrite = 1'h1;
		tick(1);
		cfgWrite = 1'h0;
		tick(2);
		chk(readData, cf[1]);
		chk({2'h0, padOeN & 8'h02}, 10'h000);
	endtask : t_readback
	initial
	begin
		{sys_rst, chipResetN, cfgLoading, cfgWrite, cfgTtl} = 5'h18;
		{cfgCell, cfgLineInvert, readCell, clockLine} = 32'h0;
		{outData, extData, extEn} = 24'h0;
		triCtl = 8'hFF;
		cfgData = pcl_pkg::CFG_DEFAULT;
		for (int i = 0; i < 8; i++)
			cf[i] = pcl_pkg::CFG_DEFAULT;
		cf[0].driveMode = pcl_pkg::DRV_ON;
		cf[1] = cf[0];
		cf[1].outInvert = 1'h1;
		cf[1].fastSlew = 1'h1;
		cf[2].driveMode = pcl_pkg::DRV_OFF;
		cf[2].inLineSel = 1'h1;
		cf[4].ctlInvert = 1'h1;
		cf[5] = cf[0];
		cf[5].outRegistered = 1'h1;
		cf[5].outLineSel = 1'h1;
		cf[7].inLatch = 1'h1;
		tick(16);
		sys_rst = 1'h0;
		load(8'h00, 1'h0);
		t_outputs();
		t_chipReset();
		t_inputs();
		t_readback();
		tally_and_finish();
	end
endmodule : pcl_pad_cell_tb

// *** pcl_pin_model.sv ***
// pcl_pin_model: package pins seen from outside, with pull-ups
// assumes padOeN low means the cell drives the pin
`timescale 1ns/1ps
module pcl_pin_model #(
	parameter int CELLS = 8
) (
	input  wire logic [CELLS-1:0] ref_clk,
	input  wire logic [CELLS-1:0] padOut,
	input  wire logic [CELLS-1:0] padOeN,
	input  wire logic [CELLS-1:0] padPullUp,
	input  wire logic [CELLS-1:0] extData,
	input  wire logic [CELLS-1:0] extEn,
	output logic      [CELLS-1:0] pin
);
	logic [CELLS-1:0] pinLast = '0;
	// floating pin without pull-up drifts to the inverse of its last level
	always_comb
	begin
		pin = (~padOeN & padOut) | (padOeN & extEn & extData)
			| (padOeN & ~extEn & (padPullUp | ~pinLast));
	end
	always_ff @(posedge ref_clk[0])
	begin
		pinLast <= pin;
	end
endmodule : pcl_pin_model

// *** pcl_pkg.sv ***
// pcl_pkg: constants and carriers for the configurable pad cell block
// assumes one clock domain; configuration bits are loaded by outside logic
//
// How it works
// - The cell hands user logic both the plain pin value and the stored input value.
// - One configuration bit makes the input storage a flip-flop or a latch.
// - Polarity is set per clock line, two lines on each of four die edges.
// - A line that clocks flip-flops on its rise opens latches while low, and the reverse.
// - All input and output storage clears while loading and while the chip reset is low.
// - One configuration bit inverts the data sent to the output driver.
// - Configuration selects driver always on, always off, or steered by the control net.
// - Effective control one turns the driver off; zero makes it drive the pin.
// - One more bit inverts the control so it becomes an output enable.
// - Configuration picks direct or registered output data.
// - The output register takes data on the rise of one of the edge's two buffered lines.
// - A weak pull-up, on by default, applies only while the pin is not driven.
// - A per-cell option selects fast or slew-limited output transitions.
// - One global bit selects TTL or CMOS input thresholds for all pads.
// - Configuration bits change only during loading and hold still otherwise.
package pcl_pkg;
	localparam int EDGE_COUNT  = 4;
	localparam int LINES_EDGE  = 2;
	localparam int LINE_COUNT  = EDGE_COUNT * LINES_EDGE;
	localparam int LINE_IDX_W  = $clog2(LINE_COUNT);
	localparam logic STORE_RESET = 1'h0;

	// driver behaviour codes
	typedef enum logic [1:0] {
		DRV_OFF   = 2'h0,
		DRV_ON    = 2'h1,
		DRV_NET   = 2'h2
	} pcl_drive_e;

	// per-cell static options
	typedef struct packed {
		logic        inLatch;     // input storage is latch
		logic        inLineSel;   // which of the edge's two lines
		logic        outInvert;
		logic        outRegistered;
		logic        outLineSel;
		pcl_drive_e  driveMode;
		logic        ctlInvert;   // control acts as enable
		logic        pullUpEn;
		logic        fastSlew;
	} pcl_cfg_s;

	localparam pcl_cfg_s CFG_DEFAULT = '{
		inLatch: 1'h0, inLineSel: 1'h0, outInvert: 1'h0,
		outRegistered: 1'h0, outLineSel: 1'h0, driveMode: DRV_NET,
		ctlInvert: 1'h0, pullUpEn: 1'h1, fastSlew: 1'h0};
endpackage : pcl_pkg

// *** pcl_storage.sv ***
// pcl_storage: one storage element, flip-flop or latch on a clock line
// assumes rise and level come from pcl_clock_lines on the same clock
`timescale 1ns/1ps
module pcl_storage (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic clear,
	input  wire logic asLatch,
	input  wire logic lineLevel,
	input  wire logic lineRise,
	input  wire logic dataIn,
	output logic      dataOut
);
	logic held_reg;
	logic held_next;

	// latch opens while line low: same line that rises for flip-flops
	always_comb
	begin
		held_next = held_reg;
		if (clear)
			held_next = pcl_pkg::STORE_RESET;
		else if (asLatch && !lineLevel)
			held_next = dataIn;
		else if (!asLatch && lineRise)
			held_next = dataIn;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			held_reg <= pcl_pkg::STORE_RESET;
		else
			held_reg <= held_next;
	end

	assign dataOut = held_reg;
endmodule : pcl_storage
